// >>> ems_params.svh
`ifndef EMS_PARAMS_SVH
`define EMS_PARAMS_SVH

// ----------------------------------------------------------------
// Address map of the external window.
// ----------------------------------------------------------------
`define EMS_BASE_HI 31
`define EMS_BASE_LO 29
`define EMS_BASE_MATCH 3'h2
`define EMS_BANK_HI 28
`define EMS_BANK_LO 26
`define EMS_OFS_HI 23
`define EMS_NBANKS 8

// ----------------------------------------------------------------
// Width and access-size codes.
// ----------------------------------------------------------------
`define EMS_W8 2'h0
`define EMS_W16 2'h1
`define EMS_W32 2'h2
`define EMS_SZ_BYTE 2'h0
`define EMS_SZ_HALF 2'h1
`define EMS_SZ_WORD 2'h2

`endif

// >>> ems_pkg.sv
package ems_pkg;

  // ----------------------------------------------------------------
  // Controller states, one-hot.
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_TURN = 5'h04,
    ST_ACCESS = 5'h08,
    ST_HOLD = 5'h10
  } ems_state_t;

  // ----------------------------------------------------------------
  // Settings of one bank.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_high;
    logic [1:0] width;
    logic [3:0] turn;
    logic [4:0] rd_wait;
    logic [4:0] wr_wait;
    logic [4:0] b_init;
    logic [4:0] b_next;
    logic wprot;
    logic burst_en;
    logic rd_lanes;
  } ems_bank_cfg_t;

endpackage : ems_pkg

// >>> ems_cfg_if.sv
`timescale 1ns/100ps
interface ems_cfg_if;
  import ems_pkg::*;
  logic [2:0] bank;
  ems_bank_cfg_t cfg;
  modport ctrl (output bank, input cfg);
  modport store (input bank, output cfg);
endinterface : ems_cfg_if

// >>> ems_bank_cfg.sv
`timescale 1ns/100ps
module ems_bank_cfg
  import ems_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] cfg_cs_high_i,
  input wire logic [15:0] cfg_width_i,
  input wire logic [31:0] cfg_turn_i,
  input wire logic [39:0] cfg_rd_wait_i,
  input wire logic [39:0] cfg_wr_wait_i,
  input wire logic [39:0] cfg_burst_init_i,
  input wire logic [39:0] cfg_burst_next_i,
  input wire logic [7:0] cfg_wprot_i,
  input wire logic [7:0] cfg_burst_en_i,
  input wire logic [7:0] cfg_rd_lanes_i,
  ems_cfg_if.store cf
);

  // ----------------------------------------------------------------
  // Per-bank slices of the flat settings ports.
  // ----------------------------------------------------------------
  ems_bank_cfg_t bank_cfg [8];

  // Each bank keeps its own settings, independent of the others.
  for (genvar i = 0; i < 8; i++) begin : g_bank
    assign bank_cfg[i] = '{cs_high: cfg_cs_high_i[i], width: cfg_width_i[2*i +: 2],
                           turn: cfg_turn_i[4*i +: 4], rd_wait: cfg_rd_wait_i[5*i +: 5],
                           wr_wait: cfg_wr_wait_i[5*i +: 5], b_init: cfg_burst_init_i[5*i +: 5],
                           b_next: cfg_burst_next_i[5*i +: 5], wprot: cfg_wprot_i[i],
                           burst_en: cfg_burst_en_i[i], rd_lanes: cfg_rd_lanes_i[i]};
  end

  // Registered read keeps the wide mux out of the controller's decode path.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cf.cfg <= '0;
    end else begin
      cf.cfg <= bank_cfg[cf.bank];
    end
  end

endmodule : ems_bank_cfg

// >>> ems_ctrl.sv
// Functional notes
// - Access is external only when address bits 31..29 equal 010.
// - Bits 28..26 pick one of eight banks; only that select asserts.
// - Address bits 25..24 are ignored, mirroring each 16 MB bank.
// - Bits 23..0 drive the 24-bit external address.
// - One select per bank, each with programmable active level.
// - Each bank has its own data width: 8, 16 or 32 bits.
// - Per-bank turnaround idle of one to sixteen cycles.
// - Read followed by write to same bank inserts turnaround cycles.
// - Separate read and write waits up to 32 cycles per bank.
// - Burst ROM uses an initial wait and a separate subsequent wait.
// - Page reads continue without repeating the full initial access.
// - Burst reads are enabled per bank.
// - Write strobe low only during a write cycle.
// - Output enable low only while memory drives read data.
// - Four byte-lane strobes; per-bank option asserts them on reads.
`timescale 1ns/100ps
`include "ems_params.svh"
module ems_ctrl
  import ems_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic req_we_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_wdata_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic resp_err_o,
  output logic [31:0] resp_rdata_o,
  input wire logic [7:0] cfg_cs_high_i,
  input wire logic [15:0] cfg_width_i,
  input wire logic [31:0] cfg_turn_i,
  input wire logic [39:0] cfg_rd_wait_i,
  input wire logic [39:0] cfg_wr_wait_i,
  input wire logic [39:0] cfg_burst_init_i,
  input wire logic [39:0] cfg_burst_next_i,
  input wire logic [7:0] cfg_wprot_i,
  input wire logic [7:0] cfg_burst_en_i,
  input wire logic [7:0] cfg_rd_lanes_i,
  output logic [7:0] bank_select_out_o,
  output logic [3:0] byte_lane_strobe_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [23:0] ext_addr_o,
  output logic [31:0] data_o,
  output logic data_oe_o,
  input wire logic [31:0] data_i
);

  // ----------------------------------------------------------------
  // State and captured request.
  // ----------------------------------------------------------------
  ems_state_t st, next_st;
  logic [4:0] cnt, next_cnt;
  logic [1:0] beats, next_beats, size;
  logic [23:0] ea, next_ea;
  logic [2:0] bank, last_bank;
  logic we, last_valid, last_rd, resp_fire;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  ems_cfg_if cf ();
  ems_bank_cfg u_cfg (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_cs_high_i(cfg_cs_high_i), .cfg_width_i(cfg_width_i),
    .cfg_turn_i(cfg_turn_i), .cfg_rd_wait_i(cfg_rd_wait_i), .cfg_wr_wait_i(cfg_wr_wait_i),
    .cfg_burst_init_i(cfg_burst_init_i), .cfg_burst_next_i(cfg_burst_next_i),
    .cfg_wprot_i(cfg_wprot_i), .cfg_burst_en_i(cfg_burst_en_i), .cfg_rd_lanes_i(cfg_rd_lanes_i),
    .cf(cf.store)
  );

  // ----------------------------------------------------------------
  // Decode and lane arithmetic.
  // ----------------------------------------------------------------
  // The bank index is forwarded in the accept cycle so settings are valid in SETUP.
  wire is_ext = req_addr_i[`EMS_BASE_HI:`EMS_BASE_LO] == `EMS_BASE_MATCH;
  wire accept = req_i && (st == ST_IDLE) && is_ext, reject = req_i && (st == ST_IDLE) && !is_ext;
  assign cf.bank = accept ? req_addr_i[`EMS_BANK_HI:`EMS_BANK_LO] : bank;
  wire [1:0] wid = cf.cfg.width;
  wire [2:0] wb = 3'h1 << wid;
  wire [1:0] lane_keep = ~(wb[1:0] - 2'h1);
  wire [1:0] cur_base = ea[1:0] & lane_keep, nxt_base = next_ea[1:0] & lane_keep;
  wire [1:0] split_beats = (size > wid) ? 2'((3'h1 << (size - wid)) - 3'h1) : 2'h0;
  wire [3:0] wmask = (wid == `EMS_W8) ? 4'h1 : (wid == `EMS_W16) ? 4'h3 : 4'hF;
  wire [3:0] lane_mask = 4'(be >> nxt_base) & wmask;
  wire [3:0] req_be = (req_size_i == `EMS_SZ_BYTE) ? 4'(4'h1 << req_addr_i[1:0]) :
                      (req_size_i == `EMS_SZ_HALF) ? 4'(4'h3 << {req_addr_i[1], 1'b0}) : 4'hF;
  wire [4:0] wait_first = we ? cf.cfg.wr_wait : (cf.cfg.burst_en ? cf.cfg.b_init : cf.cfg.rd_wait);
  wire turn_need = we && last_valid && last_rd && (last_bank == bank);
  wire beat_end = (st == ST_ACCESS) && (cnt == 5'h00);
  wire [23:0] ea_inc = 24'(ea + {21'h0, wb});
  wire next_on_bus = (next_st == ST_ACCESS) || (next_st == ST_HOLD);
  wire [7:0] next_act = next_on_bus ? 8'(8'h01 << bank) : 8'h00;

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  // Waits are counted down from the programmed value, so value N gives N+1 cycles.
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_beats = beats;
    next_ea = ea;
    resp_fire = 1'b0;
    case (st)
      ST_IDLE: begin
        if (accept) begin
          next_st = ST_SETUP;
          next_ea = req_addr_i[`EMS_OFS_HI:0];
        end
      end
      ST_SETUP: begin
        next_beats = split_beats;
        if (turn_need) begin
          next_st = ST_TURN;
          next_cnt = {1'b0, cf.cfg.turn};
        end else begin
          next_st = ST_ACCESS;
          next_cnt = wait_first;
        end
      end
      ST_TURN: begin
        if (cnt == 5'h00) begin
          next_st = ST_ACCESS;
          next_cnt = wait_first;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      ST_ACCESS: begin
        if (cnt != 5'h00) begin
          next_cnt = cnt - 5'h01;
        end else if (!we && cf.cfg.burst_en && beats != 2'h0) begin
          next_beats = beats - 2'h1;
          next_ea = ea_inc;
          next_cnt = cf.cfg.b_next;
        end else begin
          next_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (beats != 2'h0) begin
          next_st = ST_ACCESS;
          next_beats = beats - 2'h1;
          next_ea = ea_inc;
          next_cnt = we ? cf.cfg.wr_wait : cf.cfg.rd_wait;
        end else begin
          next_st = ST_IDLE;
          resp_fire = 1'b1;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end
  // State registers; the request is captured once on acceptance.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= ST_IDLE;
      cnt <= 5'h00;
      beats <= 2'h0;
      ea <= 24'h000000;
      bank <= 3'h0;
      we <= 1'b0;
      size <= 2'h0;
      wdata <= 32'h00000000;
      be <= 4'h0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      beats <= next_beats;
      ea <= next_ea;
      if (accept) begin
        bank <= req_addr_i[`EMS_BANK_HI:`EMS_BANK_LO];
        we <= req_we_i;
        size <= req_size_i;
        wdata <= req_wdata_i;
        be <= req_be;
      end
    end
  end
  // Remember the last finished access for the read-to-write turnaround.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_valid <= 1'b0;
      last_rd <= 1'b0;
      last_bank <= 3'h0;
    end else if (resp_fire) begin
      last_valid <= 1'b1;
      last_rd <= !we;
      last_bank <= bank;
    end
  end
  // Each system byte lane takes the matching external lane at the end of a read beat.
  for (genvar k = 0; k < 4; k++) begin : g_lane
    wire [2:0] lk = 3'(k);
    wire hit = (lk >= {1'b0, cur_base}) && (lk < 3'({1'b0, cur_base} + wb));
    wire [7:0] lane_byte = 8'(data_i >> {2'(lk[1:0] - cur_base), 3'h0});
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        rdata[8*k +: 8] <= 8'h00;
      end else if (beat_end && !we && hit) begin
        rdata[8*k +: 8] <= lane_byte;
      end
    end
  end
  // ----------------------------------------------------------------
  // Registered pins, computed from the next state so they line up with it.
  // ----------------------------------------------------------------
  // Protected writes still run their timing but never strobe, so software sees a normal completion.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b1;
      resp_valid_o <= 1'b0;
      resp_err_o <= 1'b0;
      resp_rdata_o <= 32'h00000000;
      bank_select_out_o <= 8'h00;
      byte_lane_strobe_n_o <= 4'hF;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      ext_addr_o <= 24'h000000;
      data_o <= 32'h00000000;
      data_oe_o <= 1'b0;
    end else begin
      req_ready_o <= next_st == ST_IDLE;
      resp_valid_o <= resp_fire || reject;
      resp_err_o <= reject;
      if (resp_fire) begin
        resp_rdata_o <= we ? 32'h00000000 : rdata;
      end
      bank_select_out_o <= ~(next_act ^ cfg_cs_high_i);
      oe_n_o <= !(next_st == ST_ACCESS && !we);
      we_n_o <= !(next_st == ST_ACCESS && we && !cf.cfg.wprot);
      byte_lane_strobe_n_o <= (next_st == ST_ACCESS && (we ? !cf.cfg.wprot : cf.cfg.rd_lanes)) ?
                              ~lane_mask : 4'hF;
      ext_addr_o <= next_ea;
      data_o <= wdata >> {nxt_base, 3'h0};
      data_oe_o <= next_on_bus && we && !cf.cfg.wprot;
    end
  end
  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  wire [7:0] act_now = ~(bank_select_out_o ^ cfg_cs_high_i);
  sequence s_beat_end;
    st == ST_ACCESS && cnt == 5'h00;
  endsequence
  sequence s_burst_go;
    s_beat_end ##0 (!we && cf.cfg.burst_en && beats != 2'h0);
  endsequence
  property p_reject;
    @(posedge clk_i) disable iff (rst_i) reject |=> resp_valid_o && resp_err_o;
  endproperty
  a_reject: assert property (p_reject) else $error("non-external access not refused");
  // The selects leave reset at the raw all-zero value, so the first edge after release is skipped.
  property p_one_sel;
    @(posedge clk_i) disable iff (rst_i) !$past(rst_i) |-> $onehot0(act_now);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("more than one bank selected");
  property p_addr;
    @(posedge clk_i) disable iff (rst_i) accept |=> ##1 ext_addr_o == $past(req_addr_i[23:0], 2);
  endproperty
  a_addr: assert property (p_addr) else $error("external address not taken from bits 23..0");
  property p_strobe_excl;
    @(posedge clk_i) disable iff (rst_i) !(we_n_o == 1'b0 && oe_n_o == 1'b0);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("write and output enable both low");
  property p_oe_sel;
    @(posedge clk_i) disable iff (rst_i) !oe_n_o |-> !we && act_now != 8'h00 && !data_oe_o;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("output enable low outside a selected read");
  property p_turn_quiet;
    @(posedge clk_i) disable iff (rst_i) st == ST_TURN |-> oe_n_o && we_n_o && !data_oe_o && act_now == 8'h00;
  endproperty
  a_turn_quiet: assert property (p_turn_quiet) else $error("bus active during turnaround");
  property p_wait;
    @(posedge clk_i) disable iff (rst_i) (st == ST_ACCESS && cnt != 5'h00) |=> st == ST_ACCESS && cnt == $past(cnt) - 5'h01;
  endproperty
  a_wait: assert property (p_wait) else $error("wait count did not step down");
  property p_burst_next;
    @(posedge clk_i) disable iff (rst_i) s_burst_go |=> st == ST_ACCESS && !oe_n_o && cnt == $past(cf.cfg.b_next);
  endproperty
  a_burst_next: assert property (p_burst_next) else $error("burst beat not using subsequent wait");
  property p_wprot;
    @(posedge clk_i) disable iff (rst_i) (st == ST_ACCESS && we && cf.cfg.wprot) |-> we_n_o && byte_lane_strobe_n_o == 4'hF;
  endproperty
  a_wprot: assert property (p_wprot) else $error("strobes on a protected bank");
  property p_rd_lanes;
    @(posedge clk_i) disable iff (rst_i) (st == ST_ACCESS && !we && !cf.cfg.rd_lanes) |-> byte_lane_strobe_n_o == 4'hF;
  endproperty
  a_rd_lanes: assert property (p_rd_lanes) else $error("byte lanes strobed on a read");
endmodule : ems_ctrl

// >>> ems_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Behavioural static memory on the far side of the external bus.
// ----------------------------------------------------------------
module ems_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic [15:0] width_i,
  input wire logic [7:0] cs_high_i,
  input wire logic [7:0] sel_i,
  input wire logic [3:0] strobe_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wdata_oe_i,
  output logic [31:0] rdata_o
);
  logic [7:0] mem [logic [26:0]];
  logic [7:0] act;
  logic [2:0] bank;
  logic [2:0] nbytes;
  logic [23:0] base;
  logic [3:0] oe_age;
  logic [31:0] last;
  logic [31:0] rd;
  logic drive;

  // Each select is decoded at its own programmed level.
  assign act = ~(sel_i ^ cs_high_i);
  always_comb begin
    bank = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (act[i]) begin
        bank = i[2:0];
      end
    end
  end
  assign nbytes = (width_i[2 * bank +: 2] == 2'h2) ? 3'h4 : ((width_i[2 * bank +: 2] == 2'h1) ? 3'h2 : 3'h1);
  assign base = addr_i & ~(24'(nbytes) - 24'h1);

  // A slow part shows garbage for three cycles after the output enable falls.
  assign drive = (|act) && !oe_n_i && !(slow_i && oe_age < 4'h3);
  // Released lanes show the inverse of the last value so stale data never matches.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rd[8 * i +: 8] = ~last[8 * i +: 8];
      if (drive && i < nbytes) begin
        rd[8 * i +: 8] = mem.exists({bank, base + 24'(i)}) ? mem[{bank, base + 24'(i)}] : 8'h00;
      end
    end
  end
  assign rdata_o = wdata_oe_i ? wdata_i : rd;

  // Track bus history and output-enable age.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_age <= 4'h0;
      last <= 32'h0;
    end else begin
      last <= rdata_o;
      oe_age <= oe_n_i ? 4'h0 : ((oe_age == 4'hF) ? oe_age : oe_age + 4'h1);
    end
  end

  // Store each strobed lane while the write strobe is low.
  always @(posedge clk_i) begin
    if ((|act) && !we_n_i) begin
      for (int i = 0; i < 4; i++) begin
        if (i < nbytes && !strobe_n_i[i]) begin
          mem[{bank, base + 24'(i)}] = wdata_i[8 * i +: 8];
        end
      end
    end
  end
endmodule : ems_mem_model

// >>> ems_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end
module ems_ctrl_tb;
  // ----------------------------------------------------------------
  // Signals and bank settings.
  // ----------------------------------------------------------------
  logic clk_i, rst_i, req_i, req_we_i, slow;
  logic [31:0] req_addr_i, req_wdata_i, resp_rdata_o, data_o, data_i;
  logic [1:0] req_size_i;
  logic req_ready_o, resp_valid_o, resp_err_o, we_n_o, oe_n_o, data_oe_o;
  logic [7:0] bank_select_out_o, act, seen, cs_high, wprot, burst_en, rd_lanes;
  logic [3:0] byte_lane_strobe_n_o;
  logic [23:0] ext_addr_o, first_addr;
  logic [15:0] width;
  logic [31:0] turn;
  logic [39:0] rd_wait, wr_wait, b_init, b_next;
  logic multi, we_seen, oe_seen, strb_seen;
  int fails = 0;
  int checks = 0;
  // Cycles to completion: 2 + beats * (wait + 2); burst reads share one hold cycle.
  int lat_w[8] = '{4, 6, 10, 4, 68, 10, 10, 4};
  int lat_r[8] = '{4, 6, 10, 8, 6, 10, 12, 4};
  localparam logic [23:0] OFF = 24'hC3_4550;

  ems_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_we_i(req_we_i), .req_addr_i(req_addr_i),
    .req_size_i(req_size_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o),
    .resp_err_o(resp_err_o), .resp_rdata_o(resp_rdata_o), .cfg_cs_high_i(cs_high), .cfg_width_i(width),
    .cfg_turn_i(turn), .cfg_rd_wait_i(rd_wait), .cfg_wr_wait_i(wr_wait), .cfg_burst_init_i(b_init),
    .cfg_burst_next_i(b_next), .cfg_wprot_i(wprot), .cfg_burst_en_i(burst_en), .cfg_rd_lanes_i(rd_lanes),
    .bank_select_out_o(bank_select_out_o), .byte_lane_strobe_n_o(byte_lane_strobe_n_o), .we_n_o(we_n_o),
    .oe_n_o(oe_n_o), .ext_addr_o(ext_addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i));
  ems_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .width_i(width), .cs_high_i(cs_high),
    .sel_i(bank_select_out_o), .strobe_n_i(byte_lane_strobe_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o),
    .addr_i(ext_addr_o), .wdata_i(data_o), .wdata_oe_i(data_oe_o), .rdata_o(data_i));

  // Clock at 10 MHz.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Bus monitor gathers what each access showed on the pins, sampled mid-cycle.
  assign act = ~(bank_select_out_o ^ cs_high);
  always @(negedge clk_i) begin
    if ((|act) && seen == 8'h00) first_addr = ext_addr_o;
    seen = seen | act;
    if ($countones(act) > 1) multi = 1'b1;
    if (!we_n_o) we_seen = 1'b1;
    if (!oe_n_o) oe_seen = 1'b1;
    if (byte_lane_strobe_n_o != 4'hF) strb_seen = 1'b1;
  end

  function automatic logic [31:0] pat(input int b);
    return 32'hA1B2_C300 + 32'(b);
  endfunction : pat

  // ----------------------------------------------------------------
  // One request, waited out and checked against the expected bus picture.
  // ----------------------------------------------------------------
  task automatic acc(input logic we, input int b, input logic [1:0] m, input logic [23:0] off,
      input logic [1:0] sz, input logic [31:0] wd, input logic [31:0] exp, input int n_exp, input logic ext);
    int n;
    logic wr_on;
    n = 0;
    wr_on = we && !wprot[b];
    @(posedge clk_i);
    req_i <= 1'b1;
    req_we_i <= we;
    req_addr_i <= {(ext ? 3'b010 : 3'b011), b[2:0], m, off};
    req_size_i <= sz;
    req_wdata_i <= wd;
    {seen, multi, we_seen, oe_seen, strb_seen} = '0;
    @(negedge clk_i);
    while (req_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    req_i <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while (resp_valid_o !== 1'b1 && n < 200);
    `CHK("latency", n_exp, n)
    `CHK("error flag", !ext, resp_err_o)
    `CHK("selects seen", (ext ? (8'h01 << b) : 8'h00), seen)
    `CHK("single select", 1'b0, multi)
    `CHK("write strobe", wr_on, we_seen)
    `CHK("output enable", ext && !we, oe_seen)
    `CHK("lane strobes", (ext && (we ? wr_on : rd_lanes[b])), strb_seen)
    if (ext) `CHK("first address", off, first_addr)
    if (ext && !we) `CHK("read data", exp, resp_rdata_o)
  endtask : acc

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {rst_i, req_i, req_we_i, slow, req_addr_i, req_size_i, req_wdata_i} = {1'b1, 37'h0, 32'h0};
    cs_high = 8'hA5;
    width = 16'h8186;
    turn = 32'h0000_000F;
    rd_wait = 40'h00_0002_0000;
    wr_wait = 40'h00_01F0_0000;
    b_init = 40'h00_8000_0000;
    b_next = 40'h00_4000_0000;
    wprot = 8'h80;
    burst_en = 8'h40;
    rd_lanes = 8'h02;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("reset selects", 8'h00, bank_select_out_o)
    `CHK("reset strobes", 3'b111, {we_n_o, oe_n_o, req_ready_o})
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK("idle selects", ~cs_high, bank_select_out_o)
    for (int b = 0; b < 8; b++) acc(1'b1, b, 2'h0, OFF, 2'h2, pat(b), 32'h0, lat_w[b], 1'b1);
    for (int b = 0; b < 8; b++) begin
      slow = (b == 3);
      acc(1'b0, b, 2'h0, OFF, 2'h2, 32'h0, ((b == 7) ? 32'h0 : pat(b)), lat_r[b], 1'b1);
    end
    slow = 1'b0;
    // The turnaround only follows a read of the same bank, so bank 0 is read first.
    acc(1'b0, 0, 2'h3, OFF, 2'h2, 32'h0, pat(0), 4, 1'b1);
    acc(1'b1, 0, 2'h1, OFF, 2'h2, 32'h0BAD_F00D, 32'h0, 20, 1'b1);
    acc(1'b0, 0, 2'h0, OFF, 2'h2, 32'h0, 32'h0BAD_F00D, 4, 1'b1);
    acc(1'b1, 2, 2'h0, OFF + 24'h3, 2'h0, 32'h5A00_0000, 32'h0, 4, 1'b1);
    acc(1'b0, 2, 2'h0, OFF, 2'h2, 32'h0, (pat(2) & 32'h00FF_FFFF) | 32'h5A00_0000, 10, 1'b1);
    acc(1'b1, 7, 2'h0, OFF, 2'h2, 32'hFFFF_FFFF, 32'h0, 4, 1'b1);
    acc(1'b0, 7, 2'h0, OFF, 2'h2, 32'h0, 32'h0, 4, 1'b1);
    acc(1'b0, 1, 2'h0, OFF, 2'h2, 32'h0, 32'h0, 1, 1'b0);
    close_out();
  end
endmodule : ems_ctrl_tb
